// File: verilog/startup_sequencer.v
// Purpose: post-configuration startup sequencer with APB registers
// Assumes: pclk 200 MHz; startup clock sources arrive as pclk-synchronous levels
// Notes:   phases advance on rising edges of the selected startup clock
//
// Summary of operation
// - startup clock is config, fabric or test-port clock; config clock by default
// - global write enable asserts at phase 1..6, completion or keep; default 6
// - block RAM read and write blocked until write enable phase reached
// - completion setting asserts write enable once completion input high
// - keep setting holds write enable at present value
// - output float released at phase 1..6, completion or keep; default 5
// - completion releases float on completion input; keep retains float value
// - optional stall at phase 0..6 for clock manager locks; no-wait default
// - optional stall at phase 0..6 for impedance match locks; auto default
// - completion signal at phase 1..6, default 4, later when pipelined
// - pipelined: wait done pin, then a startup clock edge, then completion
// - done pin open-drain by default, optional active high drive
// - persistence keeps configuration pins after startup, per mode
// - CRC check on by default; off selects fixed pattern check
// - clock manager reset on halt plus global-high commands when enabled
// - done pin reused as sleep indication after completion when enabled
// - 32-bit revision code, default 0x0fffffff pattern as printed
// - master-mode config clock rate selectable 4 to 130 MHz, default 4
`timescale 1ns/1ps
module startup_sequencer (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        config_clock,
  input  wire        fabric_clock_source,
  input  wire        test_port_clock_source,
  input  wire        clock_manager_locked,
  input  wire        impedance_control_locked,
  input  wire        done_pin_in,
  input  wire        sleep_request,
  output reg         done_pin_out,
  output reg         done_pin_oe,
  output reg         global_write_enable,
  output reg         global_output_float,
  output reg         block_ram_enable,
  output reg         config_pins_persist,
  output reg         parallel_pins_persist,
  output reg         readback_allowed,
  output reg         reconfig_allowed,
  output reg         fixed_pattern_check,
  output reg         clock_manager_reset,
  output reg  [7:0]  config_clock_rate,
  output reg  [31:0] design_revision_code
);
`include "startup_seq_regs.vh"

  reg  [31:0] ctrl_reg;
  reg  [31:0] config_reg;
  reg  [7:0]  rate_reg;
  reg  [31:0] revision_reg;
  reg  [2:0]  phase_reg;
  reg         running_reg;
  reg         finished_reg;
  reg         clk_prev_reg;
  reg         done_act_reg;
  reg         pipe_wait_reg;
  reg         pipe_done_reg;
  reg         halt_seen_reg;
  reg  [31:0] rdata_next;
  reg         seq_clk;
  reg         lock_hold;
  wire        we_level;
  wire        float_level;
  wire        acc;
  wire        wr;
  wire        step;
  wire        restart;
  wire        completion_input;
  wire [3:0]  we_sel;
  wire [3:0]  float_sel;
  wire [2:0]  done_sel;
  wire [3:0]  lock_sel;
  wire [3:0]  match_sel;
  wire [1:0]  security;
  wire        mapped;

  assign acc       = psel && penable;
  assign wr        = acc && pwrite;
  assign we_sel    = config_reg[`CFG_WE_LO+3:`CFG_WE_LO];
  assign float_sel = config_reg[`CFG_FLOAT_LO+3:`CFG_FLOAT_LO];
  assign done_sel  = config_reg[`CFG_DONE_LO+2:`CFG_DONE_LO];
  assign lock_sel  = config_reg[`CFG_LOCK_LO+3:`CFG_LOCK_LO];
  assign match_sel = config_reg[`CFG_MATCH_LO+3:`CFG_MATCH_LO];
  assign security  = ctrl_reg[`CTRL_SECURITY_HI:`CTRL_SECURITY_LO];
  assign mapped    = paddr == `CTRL_OFS || paddr == `CONFIG_OFS || paddr == `CMD_OFS ||
                     paddr == `STATUS_OFS || paddr == `REVISION_OFS || paddr == `RATE_OFS;

  ////////////////////////////////////////////////////////////////////////////
  // startup clock select and edge detect
  always @* begin
    case (ctrl_reg[`CTRL_CLKSEL_HI:`CTRL_CLKSEL_LO])
      `CLK_CONFIG: seq_clk = config_clock;
      `CLK_FABRIC: seq_clk = fabric_clock_source;
      `CLK_TEST:   seq_clk = test_port_clock_source;
      default:     seq_clk = config_clock;
    endcase
  end

  // lock waits stall the phase selected for them
  always @* begin
    lock_hold = 1'b0;
    if (lock_sel != `PH_NOWAIT && lock_sel < 4'h7 &&
        {1'b0, phase_reg} == lock_sel && !clock_manager_locked)
      lock_hold = 1'b1;
    if (match_sel != `PH_NOWAIT && !impedance_control_locked) begin
      if (match_sel == `PH_AUTO && phase_reg == `AUTO_MATCH_PHASE)
        lock_hold = 1'b1;
      else if (match_sel < 4'h7 && {1'b0, phase_reg} == match_sel)
        lock_hold = 1'b1;
    end
  end

  assign step    = running_reg && seq_clk && !clk_prev_reg && !lock_hold;
  assign restart = wr && paddr == `CTRL_OFS && pwdata[`CTRL_START] && !running_reg;
  // completion input: pin level, or its copy after a startup edge when pipelined
  assign completion_input = ctrl_reg[`CTRL_PIPE] ? pipe_done_reg
                                                 : (done_pin_in && done_act_reg);

  ////////////////////////////////////////////////////////////////////////////
  // phase counter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg     <= 3'h0;
      running_reg   <= 1'b0;
      finished_reg  <= 1'b0;
      clk_prev_reg  <= 1'b0;
      done_act_reg  <= 1'b0;
      pipe_wait_reg <= 1'b0;
      pipe_done_reg <= 1'b0;
    end else begin
      clk_prev_reg <= seq_clk;
      if (restart) begin
        phase_reg     <= 3'h0;
        running_reg   <= 1'b1;
        finished_reg  <= 1'b0;
        done_act_reg  <= 1'b0;
        pipe_wait_reg <= 1'b0;
        pipe_done_reg <= 1'b0;
      end else if (step) begin
        phase_reg <= phase_reg + 3'h1;
        if (phase_reg + 3'h1 == done_sel)
          done_act_reg <= 1'b1;
        if (phase_reg + 3'h1 == `LAST_PHASE)
          running_reg <= 1'b0;
      end
      // pipelined: done pin seen, then one more startup edge
      if (!restart && ctrl_reg[`CTRL_PIPE] && done_act_reg && done_pin_in)
        pipe_wait_reg <= 1'b1;
      if (!restart && pipe_wait_reg && seq_clk && !clk_prev_reg)
        pipe_done_reg <= 1'b1;
      if (!restart && completion_input)
        finished_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write enable and output float actions
  phase_action u_we (
    .pclk             (pclk),
    .presetn          (presetn),
    .restart          (restart),
    .step             (step),
    .phase            (phase_reg),
    .select           (we_sel),
    .completion_input (completion_input),
    .init_level       (1'b0),
    .level            (we_level)
  );

  // level marks the release, so reset leaves outputs floated and keep holds them as they are
  phase_action u_float (
    .pclk             (pclk),
    .presetn          (presetn),
    .restart          (restart),
    .step             (step),
    .phase            (phase_reg),
    .select           (float_sel),
    .completion_input (completion_input),
    .init_level       (1'b0),
    .level            (float_level)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg      <= `CTRL_RESET;
      config_reg    <= `CONFIG_RESET;
      rate_reg      <= `RATE_RESET;
      revision_reg  <= `REVISION_RESET;
      halt_seen_reg <= 1'b0;
    end else begin
      if (wr && paddr == `CTRL_OFS)
        ctrl_reg <= {20'h00000, pwdata[11:1], 1'b0};
      if (wr && paddr == `CONFIG_OFS && !running_reg)
        config_reg <= {12'h000, pwdata[19:0]};
      if (wr && paddr == `RATE_OFS && pwdata[7:0] >= `RATE_RESET && pwdata[7:0] <= `RATE_MAX)
        rate_reg <= pwdata[7:0];
      if (wr && paddr == `REVISION_OFS)
        revision_reg <= pwdata;
      if (wr && paddr == `CMD_OFS && pwdata[`CMD_HALT])
        halt_seen_reg <= 1'b1;
      else if (wr && paddr == `CMD_OFS && pwdata[`CMD_GLOBAL_HIGH])
        halt_seen_reg <= 1'b0;
    end
  end

  always @* begin
    rdata_next = 32'h00000000;
    case (paddr)
      `CTRL_OFS:     rdata_next = {ctrl_reg[31:1], running_reg};
      `CONFIG_OFS:   rdata_next = config_reg;
      `STATUS_OFS:   rdata_next = {24'h000000, finished_reg, done_act_reg, lock_hold,
                                   global_write_enable, phase_reg, running_reg};
      `REVISION_OFS: rdata_next = (security == 2'h0) ? revision_reg : 32'h00000000;
      `RATE_OFS:     rdata_next = {24'h000000, rate_reg};
      default:       rdata_next = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus answer and registered outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata                <= 32'h00000000;
      pready                <= 1'b0;
      pslverr               <= 1'b0;
      done_pin_out          <= 1'b0;
      done_pin_oe           <= 1'b0;
      global_write_enable   <= 1'b0;
      global_output_float   <= 1'b1;
      block_ram_enable      <= 1'b0;
      config_pins_persist   <= 1'b0;
      parallel_pins_persist <= 1'b0;
      readback_allowed      <= 1'b1;
      reconfig_allowed      <= 1'b1;
      fixed_pattern_check   <= 1'b0;
      clock_manager_reset   <= 1'b0;
      config_clock_rate     <= `RATE_RESET;
      design_revision_code  <= `REVISION_RESET;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= (psel && !penable && !pwrite) ? rdata_next : 32'h00000000;
      global_write_enable <= we_level;
      block_ram_enable    <= we_level;
      global_output_float <= ~float_level;
      if (finished_reg && ctrl_reg[`CTRL_SLEEP_PIN]) begin
        done_pin_out <= ~sleep_request;
        done_pin_oe  <= ctrl_reg[`CTRL_DRIVE] ? 1'b1 : sleep_request;
      end else begin
        done_pin_out <= done_act_reg && ctrl_reg[`CTRL_DRIVE];
        done_pin_oe  <= ctrl_reg[`CTRL_DRIVE] ? done_act_reg : ~done_act_reg;
      end
      config_pins_persist   <= finished_reg && ctrl_reg[`CTRL_PERSIST];
      parallel_pins_persist <= finished_reg && ctrl_reg[`CTRL_PERSIST] &&
                               ctrl_reg[`CTRL_PMODE];
      readback_allowed      <= security == 2'h0;
      reconfig_allowed      <= security != 2'h2;
      fixed_pattern_check   <= ~ctrl_reg[`CTRL_CRC_EN];
      clock_manager_reset   <= ctrl_reg[`CTRL_CM_RESET] && halt_seen_reg &&
                               wr && paddr == `CMD_OFS && pwdata[`CMD_GLOBAL_HIGH];
      config_clock_rate     <= rate_reg;
      design_revision_code  <= revision_reg;
    end
  end

endmodule

// File: verilog/startup_seq_regs.vh
// Purpose: register offsets, fields and reset values of the startup sequencer
// Assumes: APB, 32-bit data, one aligned word per register
// Notes:   definitions only
`ifndef STARTUP_SEQ_REGS_VH
`define STARTUP_SEQ_REGS_VH

`define CTRL_OFS         12'h000
`define CONFIG_OFS       12'h004
`define CMD_OFS          12'h008
`define STATUS_OFS       12'h00c
`define REVISION_OFS     12'h010
`define RATE_OFS         12'h014

// control: start request and option bits
`define CTRL_START       0
`define CTRL_PIPE        1
`define CTRL_DRIVE       2
`define CTRL_PERSIST     3
`define CTRL_SLEEP_PIN   4
`define CTRL_CRC_EN      5
`define CTRL_CM_RESET    6
`define CTRL_SECURITY_LO 7
`define CTRL_SECURITY_HI 8
`define CTRL_PMODE       9
`define CTRL_CLKSEL_LO   10
`define CTRL_CLKSEL_HI   11
`define CTRL_RESET       32'h00000070

// config: phase selections, 4 bits each, done select uses only the low 3
`define CFG_WE_LO        0
`define CFG_FLOAT_LO     4
`define CFG_DONE_LO      8
`define CFG_LOCK_LO      12
`define CFG_MATCH_LO     16
`define CONFIG_RESET     32'h00087456

// phase select encodings
`define PH_COMPLETE      4'h7
`define PH_KEEP          4'h8
`define PH_NOWAIT        4'h7
`define PH_AUTO          4'h8
`define AUTO_MATCH_PHASE 3'h6

// clock source select
`define CLK_CONFIG       2'h0
`define CLK_FABRIC       2'h1
`define CLK_TEST         2'h2

// commands
`define CMD_HALT         0
`define CMD_GLOBAL_HIGH  1

`define REVISION_RESET   32'h0fffffff
`define RATE_RESET       8'h04
`define RATE_MAX         8'h82
`define LAST_PHASE       3'h7
`endif

// File: verilog/phase_action.v
// Purpose: one startup action, set on reaching its phase
// Assumes: phase select of 1..6, completion or keep
// Notes:   keep holds the current level
`timescale 1ns/1ps
module phase_action (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       restart,
  input  wire       step,
  input  wire [2:0] phase,
  input  wire [3:0] select,
  input  wire       completion_input,
  input  wire       init_level,
  output reg        level
);
`include "startup_seq_regs.vh"

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= 1'b0;
    end else if (restart && select != `PH_KEEP) begin
      level <= init_level;
    end else if (select == `PH_KEEP) begin
      level <= level;
    end else if (select == `PH_COMPLETE) begin
      if (completion_input)
        level <= ~init_level;
    end else if (step && {1'b0, phase} + 4'h1 == select) begin
      level <= ~init_level;
    end
  end

endmodule

// File: verif/done_line_peer.sv
// Purpose: other device sharing the done wire
// Assumes: wire pulled up when nobody pulls it low
// Notes:   hold_low keeps the shared wire low
`timescale 1ns/1ps
module done_line_peer (
  input  logic hold_low,
  input  logic done_pin_out,
  input  logic done_pin_oe,
  output logic done_wire
);
  // peer pulls low; otherwise device drive or pull-up
  assign done_wire = hold_low ? 1'b0 : (done_pin_oe ? done_pin_out : 1'b1);
endmodule

// File: verif/startup_sequencer_assertions.sv
// Purpose: port checks of the startup sequencer
// Assumes: zero-wait APB slave, registered outputs
// Notes:   bound to every instance
`timescale 1ns/1ps
module startup_sequencer_checker (
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pready,
  input logic        pslverr,
  input logic [31:0] prdata,
  input logic        global_write_enable,
  input logic        block_ram_enable,
  input logic        global_output_float,
  input logic        readback_allowed,
  input logic        reconfig_allowed,
  input logic        clock_manager_reset,
  input logic [7:0]  config_clock_rate,
  input logic [31:0] design_revision_code
);
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  a_apb_answer: assert property (s_setup |=> s_answer)
    else $error("apb answer not one cycle after setup");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("slave error outside access");
  a_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero when idle");
  a_ram_gate_we: assert property (block_ram_enable == global_write_enable)
    else $error("block ram enable differs from write enable");
  a_rate_in_range: assert property (config_clock_rate inside {[8'h04:8'h82]})
    else $error("config clock rate out of range");
  a_cm_reset_pulse: assert property ($rose(clock_manager_reset) |=> !clock_manager_reset)
    else $error("clock manager reset longer than one cycle");
  a_security_order: assert property (!reconfig_allowed |-> !readback_allowed)
    else $error("readback open while reconfiguration blocked");
  a_reset_levels: assert property ($rose(presetn) |->
    (global_output_float && !global_write_enable && design_revision_code == 32'h0fffffff)
    ##1 global_output_float)
    else $error("levels wrong after reset");
endmodule
bind startup_sequencer startup_sequencer_checker i_startup_sequencer_checker (
  .pclk, .presetn, .psel, .penable, .pready, .pslverr, .prdata, .global_write_enable,
  .block_ram_enable, .global_output_float, .readback_allowed, .reconfig_allowed,
  .clock_manager_reset, .config_clock_rate, .design_revision_code);

// File: verif/post_config_startup_sequencer_bench.sv
// Purpose: self-checking bench of the startup sequencer
// Assumes: startup clock toggled only during runs
// Notes:   expectations are written inline at each check
`timescale 1ns/1ps
module post_config_startup_sequencer_bench;
  logic        pclk, presetn, psel, penable, pwrite, pslverr, pready, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, lfsr;
  logic        cfg_clk, cm_lock, ic_lock, hold_low, done_wire, done_pin_out, done_pin_oe;
  logic        we_out, gfloat, ram_en, rb_ok, rc_ok, fixed_chk, cm_rst;
  logic        fab_clk, sleep_req, persist, ppersist;
  logic [31:0] rev_code;
  logic [7:0]  rate, exp_rate, v;
  int          miscompares, n_compared, n_pulse;

  startup_sequencer i_startup_sequencer (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .config_clock(cfg_clk), .fabric_clock_source(fab_clk), .test_port_clock_source(1'b0),
    .clock_manager_locked(cm_lock), .impedance_control_locked(ic_lock),
    .done_pin_in(done_wire), .sleep_request(sleep_req), .done_pin_out, .done_pin_oe,
    .global_write_enable(we_out), .global_output_float(gfloat), .block_ram_enable(ram_en),
    .config_pins_persist(persist), .parallel_pins_persist(ppersist), .readback_allowed(rb_ok),
    .reconfig_allowed(rc_ok), .fixed_pattern_check(fixed_chk),
    .clock_manager_reset(cm_rst), .config_clock_rate(rate), .design_revision_code(rev_code));
  done_line_peer i_done_line_peer (.hold_low, .done_pin_out, .done_pin_oe, .done_wire);

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) if (cm_rst === 1'b1) n_pulse++;

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic complete_run();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk("pready wait", 1, n);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic x);
    apb(1'b0, a, 32'h0);
    chk("prdata", e, rd);
    chk("pslverr", x, err);
  endtask
  task automatic run(input int n, input bit fab = 1'b0);
    repeat (n) begin
      if (fab)
        fab_clk <= 1'b1;
      else
        cfg_clk <= 1'b1;
      repeat (2) @(posedge pclk);
      cfg_clk <= 1'b0;
      fab_clk <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  initial begin
    {psel, penable, pwrite, cfg_clk, fab_clk, sleep_req, hold_low, cm_lock, presetn} = '0;
    {paddr, pwdata, miscompares, n_compared, n_pulse} = '0;
    ic_lock = 1'b1;
    lfsr = 32'h1477;
    exp_rate = 8'h04;
    do_reset();
    rchk(12'h000, 32'h70, 1'b0);
    rchk(12'h004, 32'h00087456, 1'b0);
    rchk(12'h010, 32'h0fffffff, 1'b0);
    rchk(12'h018, 32'h0, 1'b1);
    for (int i = 0; i < 7; i++) begin
      lfsr = nxt(lfsr);
      v = (i == 0) ? 8'h82 : (i == 1) ? 8'h83 : (i == 2) ? 8'h03 : lfsr[7:0];
      apb(1'b1, 12'h014, {24'h0, v});
      if (v >= 8'h04 && v <= 8'h82)
        exp_rate = v;
      rchk(12'h014, exp_rate, 1'b0);
      chk("rate", exp_rate, rate);
    end
    $display("test registers done");
    apb(1'b1, 12'h000, 32'h71);
    for (int k = 1; k < 8; k++) begin
      run(1);
      chk("we", k >= 6, we_out);
      chk("block ram", k >= 6, ram_en);
      chk("float", k < 5, gfloat);
      chk("done", k >= 4, done_wire);
      chk("oe", k < 4, done_pin_oe);
    end
    apb(1'b0, 12'h00c, 32'h0);
    chk("finished", 1, rd[7]);
    chk("running", 0, rd[0]);
    chk("persist", 0, persist);
    apb(1'b1, 12'h000, 32'h74);
    repeat (2) @(posedge pclk);
    chk("drive", 2'b11, {done_pin_oe, done_pin_out});
    $display("test default startup done");
    do_reset();
    hold_low <= 1'b1;
    apb(1'b1, 12'h004, 32'h00072487);
    apb(1'b1, 12'h000, 32'h71);
    run(5);
    apb(1'b0, 12'h00c, 32'h0);
    chk("phase", 2, rd[3:1]);
    chk("hold", 1, rd[5]);
    cm_lock <= 1'b1;
    run(5);
    chk("we", 0, we_out);
    chk("float", 1, gfloat);
    hold_low <= 1'b0;
    repeat (6) @(posedge pclk);
    chk("we", 1, we_out);
    chk("float", 1, gfloat);
    $display("test lock and completion done");
    apb(1'b1, 12'h000, 32'h50);
    apb(1'b1, 12'h008, 32'h1);
    apb(1'b1, 12'h008, 32'h2);
    repeat (3) @(posedge pclk);
    chk("cm pulses", 1, n_pulse);
    chk("fixed", 1, fixed_chk);
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, 12'h000, 32'h50 | (s << 7));
      repeat (2) @(posedge pclk);
      chk("readback", s == 0, rb_ok);
      chk("reconfig", s < 2, rc_ok);
      rchk(12'h010, (s == 0) ? 32'h0fffffff : 32'h0, 1'b0);
    end
    $display("test security done");
    do_reset();
    ic_lock <= 1'b0;
    apb(1'b1, 12'h000, 32'h67b);
    run(2);
    apb(1'b0, 12'h00c, 32'h0);
    chk("phase", 0, rd[3:1]);
    run(4, 1'b1);
    apb(1'b0, 12'h00c, 32'h0);
    chk("phase", 4, rd[3:1]);
    chk("done active", 1, rd[6]);
    chk("finished", 0, rd[7]);
    run(3, 1'b1);
    apb(1'b0, 12'h00c, 32'h0);
    chk("phase", 6, rd[3:1]);
    chk("hold", 1, rd[5]);
    chk("finished", 1, rd[7]);
    chk("persist", 1, persist);
    chk("parallel persist", 1, ppersist);
    ic_lock <= 1'b1;
    run(1, 1'b1);
    chk("we", 1, we_out);
    sleep_req <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("sleep pin", 0, done_wire);
    sleep_req <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("sleep pin", 1, done_wire);
    lfsr = nxt(lfsr);
    apb(1'b1, 12'h010, lfsr);
    repeat (2) @(posedge pclk);
    chk("revision code", lfsr, rev_code);
    rchk(12'h010, lfsr, 1'b0);
    $display("test options done");
    complete_run();
  end
  initial begin
    #100000;
    miscompares++;
    complete_run();
  end
endmodule
